// >>> core/svm_monitor.sv
// Supply voltage monitor: level-0 reset, level-2 crossing interrupt, Avalon-MM registers
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module svm_monitor
  import svm_pkg::*;
#(
  parameter int HOLD_CYCLES = RESET_HOLD_CYC
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire svm_pkg::svm_cmp_t CMP_IN,
  output svm_pkg::svm_fetch_req_t FETCH,
  input wire logic FETCH_ACK,
  input wire logic [7:0] FETCH_DATA,
  output logic SYS_RESET_N,
  output logic IRQ
);
  // ==========================================================================
  // Declarations
  svm_cmp_t cmp;
  svm_l2ctl_t l2ctl;
  logic above_l2_q;
  logic level2_event;
  logic [IRQ_WIDTH-1:0] irq_status;
  logic [IRQ_WIDTH-1:0] irq_mask;
  logic [IRQ_WIDTH-1:0] irq_set;
  logic level0_reset_enable;
  logic [7:0] boot_word;
  logic boot_done;
  logic boot_done_q;
  logic ack;
  logic wr_fire;
  logic rd_take;
  logic [31:0] next_readdata;
  logic [15:0] hold_cnt;
  logic in_reset;
  logic reset_cause;

  // ==========================================================================
  // Comparator inputs come from the analog side, so they are synchronised
  svm_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk(CLK),
    .arst_n(ARST_N),
    .din(CMP_IN),
    .dout(cmp)
  );

  // ==========================================================================
  // Boot option word fetch
  svm_boot_fetch u_boot (
    .clk(CLK),
    .arst_n(ARST_N),
    .fetch(FETCH),
    .fetch_ack(FETCH_ACK),
    .fetch_data(FETCH_DATA),
    .boot_word(boot_word),
    .done(boot_done)
  );

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      boot_done_q <= 1'b0;
    else
      boot_done_q <= boot_done;
  end

  // ==========================================================================
  // Avalon-MM slave: one wait cycle, then the answer
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack;
  assign wr_fire = AVS_WRITE & ack;
  assign rd_take = AVS_READ & ~ack;

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      ack <= 1'b0;
    else
      ack <= (AVS_READ | AVS_WRITE) & ~ack;
  end

  always_comb
  begin
    next_readdata = 32'h0000_0000;
    unique case (AVS_ADDRESS)
      OFS_L2_CTRL:
      begin
        next_readdata[L2_ENABLE_BIT] = l2ctl.level2_monitor_enable;
        next_readdata[L2_PASSAGE_BIT] = l2ctl.level2_passage_flag;
        next_readdata[L2_DIR_BIT] = l2ctl.level2_direction_select;
      end
      OFS_DET_STATUS:
      begin
        next_readdata[DET_ABOVE_L2_BIT] = cmp.above_level2;
        next_readdata[DET_ABOVE_L0_BIT] = cmp.above_level0;
        next_readdata[DET_BOOT_DONE_BIT] = boot_done;
      end
      OFS_IRQ_STATUS: next_readdata[IRQ_WIDTH-1:0] = irq_status;
      OFS_IRQ_MASK: next_readdata[IRQ_WIDTH-1:0] = irq_mask;
      OFS_L0_CTRL:
      begin
        next_readdata[L0_ENABLE_BIT] = level0_reset_enable;
        next_readdata[L0_BOOTWORD_LSB +: 8] = boot_word;
      end
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      AVS_READDATA <= 32'h0000_0000;
    else if (rd_take)
      AVS_READDATA <= next_readdata;
  end

  // ==========================================================================
  // Level-2 crossing detection, unfiltered so that events follow the comparator
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      above_l2_q <= 1'b0;
    else
      above_l2_q <= cmp.above_level2;
  end

  always_comb
  begin
    level2_event = 1'b0;
    if (l2ctl.level2_monitor_enable)
    begin
      if (!l2ctl.level2_direction_select)
        level2_event = cmp.above_level2 & ~above_l2_q;
      else
        level2_event = ~cmp.above_level2 & above_l2_q;
    end
  end

  // ==========================================================================
  // Level-2 control register; a passage in the write cycle beats the clear
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      l2ctl.level2_monitor_enable <= 1'b0;
      l2ctl.level2_direction_select <= 1'b0;
    end
    else if (wr_fire && AVS_ADDRESS == OFS_L2_CTRL && AVS_BYTEENABLE[0])
    begin
      l2ctl.level2_monitor_enable <= AVS_WRITEDATA[L2_ENABLE_BIT];
      l2ctl.level2_direction_select <= AVS_WRITEDATA[L2_DIR_BIT];
    end
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      l2ctl.level2_passage_flag <= 1'b0;
    else if (level2_event)
      l2ctl.level2_passage_flag <= 1'b1;
    else if (wr_fire && AVS_ADDRESS == OFS_L2_CTRL && AVS_BYTEENABLE[0]
             && !AVS_WRITEDATA[L2_PASSAGE_BIT])
      l2ctl.level2_passage_flag <= 1'b0;
  end

  // ==========================================================================
  // Interrupt status (write one to clear, set wins) and mask
  assign irq_set = {boot_done & ~boot_done_q, level2_event};

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      irq_status <= '0;
    else if (wr_fire && AVS_ADDRESS == OFS_IRQ_STATUS && AVS_BYTEENABLE[0])
      irq_status <= (irq_status & ~AVS_WRITEDATA[IRQ_WIDTH-1:0]) | irq_set;
    else
      irq_status <= irq_status | irq_set;
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      irq_mask <= IRQ_MASK_RESET;
    else if (wr_fire && AVS_ADDRESS == OFS_IRQ_MASK && AVS_BYTEENABLE[0])
      irq_mask <= AVS_WRITEDATA[IRQ_WIDTH-1:0];
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      IRQ <= 1'b0;
    else
      IRQ <= |(irq_status & irq_mask);
  end

  // ==========================================================================
  // Level-0 reset arming: loaded from the boot word, then software may change it
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      level0_reset_enable <= 1'b0;
    else if (boot_done & ~boot_done_q)
      level0_reset_enable <= ~boot_word[BOOT_L0_BIT];
    else if (wr_fire && AVS_ADDRESS == OFS_L0_CTRL && AVS_BYTEENABLE[0])
      level0_reset_enable <= AVS_WRITEDATA[L0_ENABLE_BIT];
  end

  // ==========================================================================
  // System reset output: held through power-on until supply is good, and
  // stretched after a brownout so the system sees a full reset
  // While a reset is pending, supply below level 0 keeps it whatever the arming bit says
  assign reset_cause = (~boot_done) | (~cmp.above_level0 & level0_reset_enable)
                       | (~cmp.above_level0 & in_reset);

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      hold_cnt <= 16'h0000;
      in_reset <= 1'b1;
    end
    else if (reset_cause)
    begin
      hold_cnt <= 16'h0000;
      in_reset <= 1'b1;
    end
    else if (in_reset)
    begin
      if (hold_cnt == 16'(HOLD_CYCLES - 1))
        in_reset <= 1'b0;
      else
        hold_cnt <= hold_cnt + 16'h0001;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      SYS_RESET_N <= 1'b0;
    else
      SYS_RESET_N <= ~in_reset;
  end
endmodule : svm_monitor

// >>> core/svm_pkg.sv
// Shared constants, register map and carrier types of the supply voltage monitor
package svm_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_HZ = 20_000_000;
  localparam int RESET_HOLD_US = 10;
  localparam int RESET_HOLD_CYC = (RESET_HOLD_US * (CLK_HZ / 1_000_000) > 0) ?
                                  RESET_HOLD_US * (CLK_HZ / 1_000_000) : 1;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_L2_CTRL = 8'h00;
  localparam logic [7:0] OFS_DET_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_L0_CTRL = 8'h10;

  // Field positions
  localparam int L2_ENABLE_BIT = 0;
  localparam int L2_PASSAGE_BIT = 2;
  localparam int L2_DIR_BIT = 7;
  localparam int DET_ABOVE_L2_BIT = 3;
  localparam int DET_ABOVE_L0_BIT = 0;
  localparam int DET_BOOT_DONE_BIT = 1;
  localparam int IRQ_L2_BIT = 0;
  localparam int IRQ_BOOT_BIT = 1;
  localparam int IRQ_WIDTH = 2;
  localparam int L0_ENABLE_BIT = 0;
  localparam int L0_BOOTWORD_LSB = 8;

  // Boot option word: fixed fetch address, level-0 enable bit, active low
  localparam logic [19:0] BOOT_WORD_ADDR = 20'hF_FFFF;
  localparam int BOOT_L0_BIT = 5;
  localparam logic [7:0] BOOT_WORD_RESET = 8'hFF;

  // Reset values
  localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 2'h0;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic above_level0;
    logic above_level2;
  } svm_cmp_t;

  typedef struct packed {
    logic level2_direction_select;
    logic level2_passage_flag;
    logic level2_monitor_enable;
  } svm_l2ctl_t;

  typedef struct packed {
    logic [19:0] addr;
    logic req;
  } svm_fetch_req_t;

  typedef enum logic [3:0] {
    BOOT_IDLE = 4'b0001,
    BOOT_REQ = 4'b0010,
    BOOT_DONE = 4'b0100,
    BOOT_SPARE = 4'b1000
  } svm_boot_state_t;

endpackage : svm_pkg

// >>> core/svm_sync.sv
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module svm_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta;

  // The first stage feeds the second stage only
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta <= '0;
      dout <= '0;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : svm_sync

// >>> core/svm_boot_fetch.sv
// One-shot fetch of the boot option word after hardware reset
`timescale 1ns/1ps
module svm_boot_fetch
  import svm_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  output svm_pkg::svm_fetch_req_t fetch,
  input wire logic fetch_ack,
  input wire logic [7:0] fetch_data,
  output logic [7:0] boot_word,
  output logic done
);
  svm_boot_state_t state;

  assign fetch.req = (state == BOOT_REQ);
  assign fetch.addr = BOOT_WORD_ADDR;
  assign done = (state == BOOT_DONE);

  // ==========================================================================
  // Sequencer: one request, held until acknowledged, then done until reset
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      state <= BOOT_IDLE;
    else
    begin
      unique case (state)
        BOOT_IDLE: state <= BOOT_REQ;
        BOOT_REQ: if (fetch_ack) state <= BOOT_DONE;
        BOOT_DONE: state <= BOOT_DONE;
        default: state <= BOOT_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      boot_word <= BOOT_WORD_RESET;
    else if (state == BOOT_REQ && fetch_ack)
      boot_word <= fetch_data;
  end
endmodule : svm_boot_fetch

// >>> tb/svm_monitor_props.sv
// Port-level assertions for the supply voltage monitor
`timescale 1ns/1ps
module svm_monitor_props
  import svm_pkg::*;
#(
  parameter int HOLD_CYCLES = 4
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire svm_pkg::svm_cmp_t CMP_IN,
  input wire svm_pkg::svm_fetch_req_t FETCH,
  input wire logic FETCH_ACK,
  input wire logic [7:0] FETCH_DATA,
  input wire logic SYS_RESET_N,
  input wire logic IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // ==========================================================================
  // Properties
  property p_one_wait; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait too long");
  property p_idle_wait; !(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST; endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("idle wait");
  property p_unmapped; AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS > 8'h10 |-> AVS_READDATA == 0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_rd_hold; !(AVS_READ && AVS_WAITREQUEST) |=> $stable(AVS_READDATA); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_boot_addr; FETCH.req |-> FETCH.addr == BOOT_WORD_ADDR; endproperty
  a_boot_addr: assert property (p_boot_addr) else $error("fetch address");
  property p_one_fetch; FETCH.req && FETCH_ACK |=> !FETCH.req [*2]; endproperty
  a_one_fetch: assert property (p_one_fetch) else $error("fetch repeated");
  property p_leave_por; $rose(SYS_RESET_N) |-> $past(CMP_IN.above_level0, 4); endproperty
  a_leave_por: assert property (p_leave_por) else $error("reset left low");
  // The status bits are sticky, so only a bus write may take the interrupt down
  property p_irq_fall;
    $fell(IRQ) |-> $past(AVS_WRITE) || $past(AVS_WRITE, 2) || $past(AVS_WRITE, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped");
  c_irq: cover property (IRQ);
  c_l0_reset: cover property ($fell(SYS_RESET_N));
  c_fetch: cover property (FETCH.req && FETCH_ACK);
endmodule : svm_monitor_props

bind svm_monitor svm_monitor_props #(.HOLD_CYCLES(HOLD_CYCLES)) u_props (
  .CLK(CLK), .ARST_N(ARST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .CMP_IN(CMP_IN),
  .FETCH(FETCH), .FETCH_ACK(FETCH_ACK), .FETCH_DATA(FETCH_DATA),
  .SYS_RESET_N(SYS_RESET_N), .IRQ(IRQ)
);

// >>> tb/svm_partner.sv
// Far-side model: comparator levels and the boot memory
`timescale 1ns/1ps
module svm_partner
  import svm_pkg::*;
(
  input wire logic clk,
  input wire svm_pkg::svm_fetch_req_t fetch,
  input wire logic [7:0] word,
  input wire logic [3:0] lag,
  input wire logic lvl0,
  input wire logic lvl2,
  output svm_pkg::svm_cmp_t cmp,
  output logic ack,
  output logic [7:0] data
);
  logic [3:0] cnt = 4'h0;
  initial ack = 1'b0;
  initial data = 8'hA5;
  // ==========================================================================
  // Raw comparator levels, no filtering
  assign cmp = {lvl0, lvl2};
  // Idle data keeps changing so a late sample cannot pass by luck
  always @(posedge clk)
  begin
    ack <= 1'b0;
    data <= ~data;
    if (fetch.req && !ack && fetch.addr == 20'hF_FFFF)
    begin
      cnt <= cnt + 4'h1;
      if (cnt >= lag)
      begin
        cnt <= 4'h0;
        ack <= 1'b1;
        data <= word;
      end
    end
  end
endmodule : svm_partner

// >>> tb/tb_svm_monitor.sv
// Self-checking bench for the supply voltage monitor
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %0t got %h exp %h", $time, g, e); end end
module tb_svm_monitor;
  import svm_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  svm_cmp_t cmp;
  svm_fetch_req_t fetch;
  logic fetch_ack;
  logic [7:0] fetch_data;
  logic sys_reset_n;
  logic irq;
  logic [7:0] word = 8'h9F;
  logic [3:0] lag = 4'h0;
  logic lvl0 = 1'b1;
  logic lvl2 = 1'b0;
  logic [31:0] exp_v;
  logic [31:0] exp_q [$];
  int n_errors = 0;
  int total_checks = 0;

  always #25 clk = ~clk;

  svm_monitor #(.HOLD_CYCLES(4)) dut (
    .CLK(clk), .ARST_N(arst_n), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .CMP_IN(cmp),
    .FETCH(fetch), .FETCH_ACK(fetch_ack), .FETCH_DATA(fetch_data),
    .SYS_RESET_N(sys_reset_n), .IRQ(irq)
  );
  svm_partner partner (
    .clk(clk), .fetch(fetch), .word(word), .lag(lag), .lvl0(lvl0), .lvl2(lvl2),
    .cmp(cmp), .ack(fetch_ack), .data(fetch_data)
  );

  // ==========================================================================
  // Tasks and read checker
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // Read: d is the expected word, queued for the checker below
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    if (!wr)
      exp_q.push_back(d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
    begin
      n_errors++;
      $display("unexpected %0t bus timeout", $time);
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wait_rst(input logic v);
    int n;
    n = 0;
    while (sys_reset_n !== v && n < 300)
    begin
      @(posedge clk);
      n++;
    end
  endtask : wait_rst

  task automatic hw_reset(input logic [7:0] w);
    word <= w;
    lag <= 4'($urandom_range(7, 0));
    arst_n <= 1'b0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
  endtask : hw_reset

  always @(posedge clk)
  begin
    if (avs_read && avs_waitrequest === 1'b0)
    begin
      exp_v = exp_q.pop_front();
      `CHK(avs_readdata, exp_v)
    end
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    n_errors++;
    $display("unexpected %0t watchdog expired", $time);
    summarize();
  end

  initial
  begin
    void'($urandom(61991));
    hw_reset(8'h9F);
    wait_rst(1'b1);
    `CHK(sys_reset_n, 1'b1)
    bus(1'b0, OFS_L0_CTRL, 32'h0000_9F01);
    bus(1'b0, OFS_DET_STATUS, 32'h0000_0003);
    bus(1'b0, OFS_IRQ_STATUS, 32'h0000_0002);
    bus(1'b1, 8'h20, $urandom);
    bus(1'b0, 8'h20, 32'h0000_0000);
    avs_byteenable <= 4'hE;
    bus(1'b1, OFS_IRQ_MASK, 32'h0000_0003);
    avs_byteenable <= 4'hF;
    bus(1'b0, OFS_IRQ_MASK, 32'h0000_0000);
    $display("boot test done");
    bus(1'b1, OFS_IRQ_MASK, 32'h0000_0003);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    bus(1'b1, OFS_IRQ_MASK, 32'h0000_0000);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    bus(1'b1, OFS_IRQ_MASK, 32'h0000_0003);
    bus(1'b1, OFS_IRQ_STATUS, 32'h0000_0002);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    $display("irq test done");
    lvl2 <= 1'b1;
    repeat (8) @(posedge clk);
    repeat (10) bus(1'b0, OFS_DET_STATUS, 32'h0000_000B);
    bus(1'b0, OFS_IRQ_STATUS, 32'h0000_0000);
    bus(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
    lvl2 <= 1'b0;
    repeat (8) @(posedge clk);
    bus(1'b0, OFS_DET_STATUS, 32'h0000_0003);
    bus(1'b1, OFS_L2_CTRL, 32'h0000_0001);
    lvl2 <= 1'b1;
    repeat (8) @(posedge clk);
    bus(1'b0, OFS_IRQ_STATUS, 32'h0000_0001);
    bus(1'b0, OFS_L2_CTRL, 32'h0000_0005);
    bus(1'b0, OFS_DET_STATUS, 32'h0000_000B);
    `CHK(irq, 1'b1)
    bus(1'b1, OFS_IRQ_STATUS, 32'h0000_0001);
    bus(1'b1, OFS_L2_CTRL, 32'h0000_0081);
    bus(1'b0, OFS_L2_CTRL, 32'h0000_0081);
    lvl2 <= 1'b0;
    repeat (8) @(posedge clk);
    bus(1'b0, OFS_IRQ_STATUS, 32'h0000_0001);
    bus(1'b0, OFS_DET_STATUS, 32'h0000_0003);
    $display("crossing test done");
    lvl0 <= 1'b0;
    wait_rst(1'b0);
    `CHK(sys_reset_n, 1'b0)
    lvl0 <= 1'b1;
    wait_rst(1'b1);
    `CHK(sys_reset_n, 1'b1)
    hw_reset(8'hBF);
    wait_rst(1'b1);
    `CHK(sys_reset_n, 1'b1)
    bus(1'b0, OFS_L0_CTRL, 32'h0000_BF00);
    lvl0 <= 1'b0;
    repeat (20) @(posedge clk);
    `CHK(sys_reset_n, 1'b1)
    bus(1'b1, OFS_L0_CTRL, 32'h0000_0001);
    wait_rst(1'b0);
    `CHK(sys_reset_n, 1'b0)
    lvl0 <= 1'b1;
    wait_rst(1'b1);
    `CHK(sys_reset_n, 1'b1)
    $display("level0 test done");
    summarize();
  end
endmodule : tb_svm_monitor
